// >>> inc/frame_parser_pkg.sv
package frame_parser_pkg;

  // Frame delimiters and frame type codes
  localparam logic [7:0]  START_DELIM      = 8'h7e;
  localparam logic [7:0]  TYPE_ROUTE       = 8'h21;
  localparam logic [7:0]  TYPE_REMOTE      = 8'h17;
  localparam logic [7:0]  TYPE_REMOTE_RSP  = 8'h97;
  localparam logic [7:0]  CSUM_GOOD        = 8'hff;

  // Byte offsets within a frame, counted from the delimiter
  localparam logic [15:0] OFF_TYPE         = 16'h0003;
  localparam logic [15:0] OFF_FRAME_ID     = 16'h0004;
  localparam logic [15:0] OFF_DEST64_FIRST = 16'h0005;
  localparam logic [15:0] OFF_DEST64_LAST  = 16'h000c;
  localparam logic [15:0] OFF_DEST16_FIRST = 16'h000d;
  localparam logic [15:0] OFF_DEST16_LAST  = 16'h000e;
  localparam logic [15:0] OFF_OPTIONS      = 16'h000f;
  localparam logic [15:0] OFF_HOPS         = 16'h0010;
  localparam logic [15:0] OFF_CMD_LO       = 16'h0011;
  localparam logic [15:0] OFF_RELAY_FIRST  = 16'h0011;
  localparam logic [15:0] OFF_RELAY_LO     = 16'h0012;
  localparam logic [15:0] OFF_LAST_ADJ     = 16'h0002;

  // Length figures: fixed part of each request, before its list
  localparam logic [15:0] ROUTE_LEN_BASE   = 16'h000e;
  localparam logic [15:0] REMOTE_LEN_MIN   = 16'h000f;

  // Route limits and table shape
  localparam logic [7:0]  MAX_HOPS         = 8'h1e;
  localparam int          RT_AW            = 6;
  localparam int          RT_DW            = 16;

  // Remote option and command codes
  localparam logic [7:0]  OPT_APPLY_NOW    = 8'h02;
  localparam logic [15:0] CMD_APPLY        = 16'h4143;
  localparam logic [15:0] CMD_WRITE_FLASH  = 16'h5752;

  // Values after reset
  localparam logic [63:0] DEST64_RST       = 64'h0;
  localparam logic [15:0] DEST16_RST       = 16'h0;

  typedef enum logic [4:0] {
    ST_HUNT   = 5'b00001,
    ST_LEN_HI = 5'b00010,
    ST_LEN_LO = 5'b00100,
    ST_BODY   = 5'b01000,
    ST_CSUM   = 5'b10000
  } parse_state_t;

  typedef struct packed {
    logic [63:0] dest64;
    logic [15:0] dest16;
    logic [7:0]  hops;
  } route_info_t;

  typedef struct packed {
    logic [7:0]  frame_id;
    logic [63:0] dest64;
    logic [15:0] dest16;
    logic [7:0]  options;
    logic [15:0] cmd;
    logic        has_param;
  } remote_req_t;

  typedef struct packed {
    logic [7:0] frame_type;
    logic [7:0] frame_id;
  } rsp_t;

endpackage : frame_parser_pkg

// >>> hw/route_table_mem.sv
module route_table_mem
  import frame_parser_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [RT_AW-1:0] wr_addr,
  input  wire logic [RT_DW-1:0] wr_data,
  // Read port
  input  wire logic [RT_AW-1:0] rd_addr,
  output logic      [RT_DW-1:0] rd_data
);

  logic [RT_DW-1:0] mem [0:(1<<RT_AW)-1];

  // Array has no reset; contents only matter once a bank is committed
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : route_table_mem

// >>> hw/source_route_frame_parser.sv
// Summary of operation
// - A frame opens with a delimiter, then a 16-bit length of the bytes between it and the checksum.
// - The last byte is 0xff minus the low byte of the sum from offset 3 on, and it is checked.
// - An accepted frame of type 0x21 writes one route entry for its destination.
// - A route-creation request never produces a response frame.
// - The byte at offset 16 counts the relay addresses, not counting source and destination.
// - A relay count of zero or above 30 drops the frame silently, table unchanged.
// - A malformed route request may be rejected with no indication at all.
// - Remote option 0x02 applies a change at once; 0x00 queues it for apply or flash write.
// - A remote request with a nonzero frame identifier is answered by a 0x97 response carrying that identifier.
module source_route_frame_parser
  import frame_parser_pkg::*;
(
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // Host byte stream
  input  wire logic                          rx_valid,
  input  wire logic [7:0]                    rx_data,
  output logic                               rx_ready,
  // Route table
  input  wire logic [4:0]                    rt_rd_idx,
  output logic [15:0]                        rt_rd_data,
  output logic                               rt_valid,
  output frame_parser_pkg::route_info_t      rt_info,
  // Remote parameter requests
  output logic                               remote_valid,
  output frame_parser_pkg::remote_req_t      remote_req,
  output logic                               param_apply_now,
  output logic                               param_queued,
  output logic                               apply_queued,
  output logic                               flash_queued,
  // Response descriptor
  output logic                               rsp_valid,
  input  wire logic                          rsp_ready,
  output frame_parser_pkg::rsp_t             rsp
);
  import frame_parser_pkg::*;

  parse_state_t state_q;
  logic [15:0]  len_q;
  logic [15:0]  off_q;
  logic [7:0]   sum_q;
  logic [7:0]   type_q;
  logic [7:0]   fid_q;
  logic [63:0]  dest64_q;
  logic [15:0]  dest16_q;
  logic [7:0]   opts_q;
  logic [7:0]   b16_q;
  logic [7:0]   b17_q;
  logic [7:0]   relay_hi_q;
  logic         bank_q;

  logic         take;
  logic         csum_ok;
  logic         route_ok;
  logic         remote_ok;
  logic         commit;
  logic [15:0]  route_len;
  logic [15:0]  relay_rel;
  logic         relay_wr;
  logic [4:0]   relay_idx;
  logic [15:0]  cmd;
  logic         has_param;

  // Stream never stalls: every stage keeps up with one byte a cycle
  assign rx_ready = 1'b1;
  assign take     = rx_valid;

  // Frame checks, evaluated while the checksum byte is offered
  assign csum_ok   = (8'(sum_q + rx_data) == CSUM_GOOD);
  assign route_len = ROUTE_LEN_BASE + {7'h0, b16_q, 1'b0};
  assign route_ok  = (type_q == TYPE_ROUTE)
                   && (b16_q != 8'h00) && (b16_q <= MAX_HOPS)
                   && (len_q == route_len);
  assign remote_ok = (type_q == TYPE_REMOTE) && (len_q >= REMOTE_LEN_MIN);
  assign commit    = (state_q == ST_CSUM) && take && csum_ok;
  assign cmd       = {b16_q, b17_q};
  assign has_param = (len_q > REMOTE_LEN_MIN);

  // Parser sequence
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_HUNT;
    end else if (take) begin
      case (state_q)
        ST_HUNT: begin
          if (rx_data == START_DELIM) begin
            state_q <= ST_LEN_HI;
          end
        end
        ST_LEN_HI: state_q <= ST_LEN_LO;
        ST_LEN_LO: begin
          // Empty frame has no type byte, so it cannot be anything
          if ({len_q[15:8], rx_data} == 16'h0) begin
            state_q <= ST_HUNT;
          end else begin
            state_q <= ST_BODY;
          end
        end
        ST_BODY: begin
          if (off_q == len_q + OFF_LAST_ADJ) begin
            state_q <= ST_CSUM;
          end
        end
        ST_CSUM: state_q <= ST_HUNT;
        default: state_q <= ST_HUNT;
      endcase
    end
  end

  // Length, offset and running sum
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      len_q <= '0;
      off_q <= OFF_TYPE;
      sum_q <= '0;
    end else if (take) begin
      if (state_q == ST_LEN_HI) begin
        len_q[15:8] <= rx_data;
      end
      if (state_q == ST_LEN_LO) begin
        len_q[7:0] <= rx_data;
        off_q      <= OFF_TYPE;
        sum_q      <= '0;
      end
      if (state_q == ST_BODY) begin
        off_q <= off_q + 16'h0001;
        sum_q <= 8'(sum_q + rx_data);
      end
    end
  end

  // Field capture by offset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      type_q   <= '0;
      fid_q    <= '0;
      dest64_q <= DEST64_RST;
      dest16_q <= DEST16_RST;
      opts_q   <= '0;
      b16_q    <= '0;
      b17_q    <= '0;
    end else if (take && state_q == ST_BODY) begin
      if (off_q == OFF_TYPE) begin
        type_q <= rx_data;
      end
      if (off_q == OFF_FRAME_ID) begin
        fid_q <= rx_data;
      end
      if (off_q >= OFF_DEST64_FIRST && off_q <= OFF_DEST64_LAST) begin
        dest64_q <= {dest64_q[55:0], rx_data};
      end
      if (off_q >= OFF_DEST16_FIRST && off_q <= OFF_DEST16_LAST) begin
        dest16_q <= {dest16_q[7:0], rx_data};
      end
      if (off_q == OFF_OPTIONS) begin
        opts_q <= rx_data;
      end
      if (off_q == OFF_HOPS) begin
        b16_q <= rx_data;
      end
      if (off_q == OFF_CMD_LO) begin
        b17_q <= rx_data;
      end
    end
  end

  // Relay list goes into the idle bank; live bank stays untouched
  assign relay_rel = off_q - OFF_RELAY_LO;
  assign relay_idx = relay_rel[5:1];
  assign relay_wr  = take && (state_q == ST_BODY) && (type_q == TYPE_ROUTE)
                   && (off_q >= OFF_RELAY_LO) && !off_q[0]
                   && (relay_rel[15:1] < 15'(MAX_HOPS));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      relay_hi_q <= '0;
    end else if (take && state_q == ST_BODY && off_q[0]) begin
      relay_hi_q <= rx_data;
    end
  end

  route_table_mem u_mem (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_en   (relay_wr),
    .wr_addr ({~bank_q, relay_idx}),
    .wr_data ({relay_hi_q, rx_data}),
    .rd_addr ({bank_q, rt_rd_idx}),
    .rd_data (rt_rd_data)
  );

  // Route commit: bank swap makes the update atomic, a bad frame is lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bank_q   <= 1'b0;
      rt_valid <= 1'b0;
      rt_info  <= '0;
    end else if (commit && route_ok) begin
      bank_q   <= ~bank_q;
      rt_valid <= 1'b1;
      rt_info  <= '{dest64: dest64_q, dest16: dest16_q, hops: b16_q};
    end
  end

  // Remote request hand-off, one pulse per good frame
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      remote_valid <= 1'b0;
      remote_req   <= '0;
    end else begin
      remote_valid <= commit && remote_ok;
      if (commit && remote_ok) begin
        remote_req <= '{frame_id: fid_q, dest64: dest64_q,
                        dest16: dest16_q, options: opts_q,
                        cmd: cmd, has_param: has_param};
      end
    end
  end

  // Immediate versus queued parameter changes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      param_apply_now <= 1'b0;
      param_queued    <= 1'b0;
      apply_queued    <= 1'b0;
      flash_queued    <= 1'b0;
    end else begin
      param_apply_now <= 1'b0;
      apply_queued    <= 1'b0;
      flash_queued    <= 1'b0;
      if (commit && remote_ok) begin
        if (cmd == CMD_APPLY) begin
          apply_queued <= param_queued;
          param_queued <= 1'b0;
        end else if (cmd == CMD_WRITE_FLASH) begin
          flash_queued <= param_queued;
        end else if (has_param && (opts_q & OPT_APPLY_NOW) != 8'h00) begin
          // An applied change also releases anything still queued
          param_apply_now <= 1'b1;
          apply_queued    <= param_queued;
          param_queued    <= 1'b0;
        end else if (has_param) begin
          param_queued <= 1'b1;
        end
      end
    end
  end

  // Response only for remote requests; a new one wins over the ack
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else if (commit && remote_ok && fid_q != 8'h00) begin
      rsp_valid <= 1'b1;
      rsp       <= '{frame_type: TYPE_REMOTE_RSP, frame_id: fid_q};
    end else if (rsp_ready) begin
      rsp_valid <= 1'b0;
    end
  end

endmodule : source_route_frame_parser

// >>> testbench/parser_props.sv
module parser_props
  import frame_parser_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Route side
  input wire logic        rt_valid,
  input wire route_info_t rt_info,
  // Remote side
  input wire logic        remote_valid,
  input wire remote_req_t remote_req,
  input wire logic        param_apply_now,
  input wire logic        param_queued,
  input wire logic        apply_queued,
  // Response
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire rsp_t        rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A stored route always has a legal relay count
  route_hops_a: assert property (rt_valid |->
    rt_info.hops inside {[8'h01:MAX_HOPS]}) else $error("bad hops");
  route_kept_a: assert property (rt_valid |=> rt_valid)
    else $error("route lost");
  // Route commits never come with a response
  route_quiet_a: assert property ($changed(rt_info) |->
    !remote_valid && !$rose(rsp_valid)) else $error("route rsp");
  rsp_type_a: assert property (rsp_valid |->
    rsp.frame_type == TYPE_REMOTE_RSP) else $error("rsp type");
  rsp_id_a: assert property ($rose(rsp_valid) |-> remote_valid &&
    rsp.frame_id == remote_req.frame_id) else $error("rsp id");
  // Pending response waits for the consumer; only a newer one replaces it
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && ($stable(rsp) || remote_valid)) else $error("rsp dropped");
  apply_now_a: assert property (param_apply_now |-> remote_valid &&
    remote_req.options[1] && remote_req.has_param) else $error("apply");
  queue_set_a: assert property ($rose(param_queued) |->
    remote_valid && !remote_req.options[1]) else $error("queue");
  pulse_short_a: assert property (remote_valid |=> !remote_valid)
    else $error("long pulse");
  cover property ($rose(rt_valid));
  cover property (param_apply_now);
  cover property (apply_queued);
endmodule : parser_props

// >>> testbench/host_frame_model.sv
module host_frame_model
  import frame_parser_pkg::*;
(
  // Clock
  input wire logic  sys_clk,
  // Byte stream towards the parser
  output logic       rx_valid,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end

  // Wrap a body with delimiter, length and checksum; bad spoils the sum
  task automatic send(input logic [7:0] body[$], input logic bad);
    logic [7:0]  sum;
    logic [15:0] len;
    logic [7:0]  fr[$];
    sum = 8'h00;
    len = 16'(body.size());
    foreach (body[i]) sum += body[i];
    fr = {START_DELIM, len[15:8], len[7:0]};
    fr = {fr, body, (CSUM_GOOD - sum) ^ {8{bad}}};
    foreach (fr[i]) begin
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_data  = fr[i];
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data; // Idle line must not look like the last byte
  endtask : send
endmodule : host_frame_model

// >>> testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import frame_parser_pkg::*;

  typedef struct {logic [7:0] hops; logic ok;} row_t;
  logic        sys_clk, rst, rx_valid, rx_ready, rt_valid, rsp_ready;
  logic [7:0]  rx_data;
  logic [4:0]  rt_rd_idx;
  logic [15:0] rt_rd_data;
  logic        remote_valid, param_apply_now, param_queued;
  logic        apply_queued, rsp_valid, flash_queued;
  logic [7:0]  no_par[$];
  route_info_t rt_info, exp_rt;
  remote_req_t remote_req;
  rsp_t        rsp;
  int          err_count, checks, cyc, n_rsp, n_now, n_apply, n_flash;
  // Good and bad relay counts, boundaries included
  row_t rows[5] = '{'{8'h01, 1}, '{8'h00, 0}, '{MAX_HOPS, 1},
                    '{8'h1f, 0}, '{8'h03, 1}};

  host_frame_model i_host (.sys_clk(sys_clk), .rx_valid(rx_valid),
                           .rx_data(rx_data));
  source_route_frame_parser i_dut (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .rx_valid        (rx_valid),
    .rx_data         (rx_data),
    .rx_ready        (rx_ready),
    .rt_rd_idx       (rt_rd_idx),
    .rt_rd_data      (rt_rd_data),
    .rt_valid        (rt_valid),
    .rt_info         (rt_info),
    .remote_valid    (remote_valid),
    .remote_req      (remote_req),
    .param_apply_now (param_apply_now),
    .param_queued    (param_queued),
    .apply_queued    (apply_queued),
    .flash_queued    (flash_queued),
    .rsp_valid       (rsp_valid),
    .rsp_ready       (rsp_ready),
    .rsp             (rsp)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pulse counters and hang guard
  always @(posedge sys_clk) begin
    n_rsp   += int'(rsp_valid === 1'b1 && rsp_ready);
    n_now   += int'(param_apply_now === 1'b1);
    n_apply += int'(apply_queued === 1'b1);
    n_flash += int'(flash_queued === 1'b1);
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [127:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Route request: zero id and options, relays a0xx in listed order
  // Drop leaves relays off the end, so the length no longer fits
  task automatic route(input logic [7:0] n, input logic bad,
                       input int drop = 0);
    logic [7:0] b[$];
    b = {TYPE_ROUTE, 8'h00, 8'h00, 8'h13, 8'ha2, 8'h00, 8'h12, 8'h34,
         8'h56, 8'h78, 8'hdd, n, 8'h00, n};
    for (int k = 0; k < int'(n) - drop; k++) b = {b, 8'ha0, 8'(k)};
    i_host.send(b, bad);
  endtask : route

  task automatic remote(input logic [7:0] id, op, input logic [15:0] c,
                        input logic [7:0] par[$]);
    logic [7:0] b[$];
    n_rsp = 0;
    n_now = 0;
    n_apply = 0;
    n_flash = 0;
    b = {TYPE_REMOTE, id, 8'h00, 8'h13, 8'ha2, 8'h00, 8'h12, 8'h34,
         8'h56, 8'h78, 8'hff, 8'hfe, op, c[15:8], c[7:0], par};
    i_host.send(b, 1'b0);
    repeat (3) @(negedge sys_clk);
  endtask : remote

  initial begin
    rst = 1'b1;
    rsp_ready = 1'b1;
    rt_rd_idx = 5'h00;
    exp_rt = '0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk("rt_valid", 0, rt_valid);
    chk("rx_ready", 1, rx_ready);
    // Route rows: stored when legal, table kept otherwise
    foreach (rows[r]) begin
      n_rsp = 0;
      route(rows[r].hops, 1'b0);
      repeat (3) @(negedge sys_clk);
      if (rows[r].ok) exp_rt = {64'h0013a20012345678,
                                8'hdd, rows[r].hops, rows[r].hops};
      chk("rt_info", exp_rt, rt_info);
      chk("route rsp", 0, n_rsp);
      rt_rd_idx = 5'(exp_rt.hops - 8'h01);
      repeat (2) @(negedge sys_clk);
      chk("last relay", {8'ha0, exp_rt.hops - 8'h01}, rt_rd_data);
    end
    // Spoiled sum and a short relay list both leave the route alone
    route(8'h02, 1'b1);
    route(8'h04, 1'b0, 1);
    repeat (3) @(negedge sys_clk);
    chk("bad kept", exp_rt, rt_info);
    // Good frame right behind them
    route(8'h05, 1'b0);
    repeat (3) @(negedge sys_clk);
    chk("after bad", {64'h0013a20012345678, 16'hdd05, 8'h05},
        rt_info);
    // Apply at once, consumer stalling
    rsp_ready = 1'b0;
    remote(8'h27, OPT_APPLY_NOW, 16'h4e49,
           '{8'h52, 8'h65, 8'h6d, 8'h6f, 8'h74, 8'h65});
    chk("rsp", {1'b1, TYPE_REMOTE_RSP, 8'h27}, {rsp_valid, rsp});
    chk("remote req", {8'h27, 64'h0013a20012345678, 16'hfffe,
        OPT_APPLY_NOW, 16'h4e49, 1'b1}, remote_req);
    chk("apply now", 1, n_now);
    rsp_ready = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("rsp taken", 1, {rsp_valid, 8'(n_rsp)});
    // Queued change, then release by the apply command
    remote(8'h68, 8'h00, 16'h4944, '{8'h04, 8'h51});
    chk("queued", {1'b1, 8'h00}, {param_queued, 8'(n_now)});
    chk("queue rsp", 1, n_rsp);
    remote(8'h00, 8'h00, CMD_APPLY, no_par);
    chk("released", 1, {param_queued, 8'(n_apply)});
    chk("no id rsp", 0, n_rsp);
    // Query without a value: answered, nothing queued or applied
    remote(8'hfa, 8'h00, 16'h5450, no_par);
    chk("query", {1'b0, 1'b0, 8'h00, 8'h01}, {remote_req.has_param,
        param_queued, 8'(n_now), 8'(n_rsp)});
    // Flash write keeps the queue; a later applied change releases it
    remote(8'h68, 8'h00, 16'h4944, '{8'h04, 8'h51});
    remote(8'h00, 8'h00, CMD_WRITE_FLASH, no_par);
    chk("flash", {1'b1, 8'h01}, {param_queued, 8'(n_flash)});
    remote(8'h27, OPT_APPLY_NOW, 16'h4e49, '{8'h52});
    chk("apply both", {1'b0, 8'h01, 8'h01},
        {param_queued, 8'(n_now), 8'(n_apply)});
    complete_run();
  end

  task automatic complete_run();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
endmodule : tb

bind source_route_frame_parser parser_props i_props (
  .sys_clk         (sys_clk),
  .rst             (rst),
  .rt_valid        (rt_valid),
  .rt_info         (rt_info),
  .remote_valid    (remote_valid),
  .remote_req      (remote_req),
  .param_apply_now (param_apply_now),
  .param_queued    (param_queued),
  .apply_queued    (apply_queued),
  .rsp_valid       (rsp_valid),
  .rsp_ready       (rsp_ready),
  .rsp             (rsp)
);
